// ===== hw/usb_periph_irq_config.sv
// Peripheral interrupt configuration, filtering, enables and status
`timescale 1ns/1ns
`include "uirq_defs.svh"
module usb_periph_irq_config
  import uirq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Handshake report from the serial interface engine
  input wire logic hsValid,
  input uirq_hs_type hsType,
  input wire logic [2:0] hsEndpoint,
  input wire logic hsDirIn,
  // Bus events: 0 SOF, 1 suspend, 2 resume, 3 setup, 4 speed status
  input wire logic [4:0] busEvent,
  input wire logic usbBusReset,
  // Interrupt pin
  output logic irqOut
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] config_reg; // Output configuration
  logic [31:0] enable_reg; // Per-source enables, also the mask
  logic [31:0] status_reg; // Sticky event flags
  logic [31:0] status_next; // Next status value
  logic globalEnable_reg; // Global interrupt enable
  logic [15:0] nakSeen_reg; // NAK already seen since last ACK or NYET
  logic pendingPrev_reg; // Pending one cycle ago
  logic [31:0] regRdData_next; // Read mux

  // Decoded strobes
  logic wrMode;
  logic wrConfig;
  logic wrEnable;
  logic wrStatus;

  // Handshake decode
  logic [3:0] hsIndex; // Endpoint and direction
  logic [1:0] hsField; // Selected filter field
  logic hsFirstNak; // NAK counts as first
  logic hsPass; // Handshake raises an event
  logic [31:0] setBits; // Events this cycle
  logic pending; // Unmasked pending and globally enabled
  logic newUnmasked; // Fresh unmasked event
  logic trigger; // Pulse request

  assign wrMode = regWrite && (regAddr == `UIRQ_OFS_MODE);
  assign wrConfig = regWrite && (regAddr == `UIRQ_OFS_CONFIG);
  assign wrEnable = regWrite && (regAddr == `UIRQ_OFS_ENABLE);
  assign wrStatus = regWrite && (regAddr == `UIRQ_OFS_STATUS);

  //////////////////////////////////////////////////////////////////////////////
  // Filter field for a transaction
  function automatic logic [1:0] selectField(
    input logic [2:0] ep,
    input logic dirIn,
    input logic [7:0] cfg
  );
    logic [1:0] fld;
    fld = 2'h0;
    if (ep == 3'h0)
      fld = cfg[`UIRQ_CFG_CTRL_HI:`UIRQ_CFG_CTRL_LO];
    else if (dirIn)
      fld = cfg[`UIRQ_CFG_DIN_HI:`UIRQ_CFG_DIN_LO];
    else
      fld = cfg[`UIRQ_CFG_DOUT_HI:`UIRQ_CFG_DOUT_LO];
    return fld;
  endfunction : selectField

  //////////////////////////////////////////////////////////////////////////////
  // Does a handshake pass the filter
  function automatic logic filterPass(
    input logic [1:0] fld,
    input uirq_hs_type hs,
    input logic firstNak,
    input logic allowNyet
  );
    logic isAck;
    logic isNak;
    logic isNyet;
    logic pass;
    isAck = (hs == UIRQ_HS_ACK);
    isNak = (hs == UIRQ_HS_NAK);
    isNyet = (hs == UIRQ_HS_NYET) && allowNyet;
    pass = 1'b0;
    if (fld == 2'h0)
      pass = isAck || isNyet || isNak;
    else if (fld == 2'h1)
      pass = isAck || isNyet;
    else
      pass = isAck || isNyet || (isNak && firstNak);
    return pass;
  endfunction : filterPass

  //////////////////////////////////////////////////////////////////////////////
  // Handshake classification
  always_comb
  begin
    hsIndex = {hsEndpoint, hsDirIn};
    hsField = selectField(hsEndpoint, hsDirIn, config_reg);
    hsFirstNak = ~nakSeen_reg[hsIndex];
    hsPass = hsValid && filterPass(hsField, hsType, hsFirstNak,
                                   (hsEndpoint != 3'h0) && !hsDirIn);
  end

  //////////////////////////////////////////////////////////////////////////////
  // First-NAK trackers, one per endpoint and direction
  genvar gi;
  generate
    for (gi = 0; gi < 2 * `UIRQ_NUM_EP; gi++)
    begin : gNak
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
          nakSeen_reg[gi] <= 1'b0;
        else if (hsValid && (hsIndex == 4'(gi)))
        begin
          if (hsType == UIRQ_HS_NAK)
            nakSeen_reg[gi] <= 1'b1;
          else if ((hsType == UIRQ_HS_ACK) || (hsType == UIRQ_HS_NYET))
            nakSeen_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Event bits raised this cycle
  always_comb
  begin
    setBits = 32'h00000000;
    setBits[`UIRQ_BIT_BUS_RESET] = usbBusReset;
    setBits[`UIRQ_BIT_SOF] = busEvent[0];
    setBits[`UIRQ_BIT_SUSPEND] = busEvent[1];
    setBits[`UIRQ_BIT_RESUME] = busEvent[2];
    setBits[`UIRQ_BIT_SETUP] = busEvent[3];
    setBits[`UIRQ_BIT_HS_STAT] = busEvent[4];
    // RX even, TX odd per endpoint
    if (hsPass)
      setBits[`UIRQ_BIT_EP_BASE + 32'(hsIndex)] = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode register, global enable only
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      globalEnable_reg <= 1'b0;
    else if (wrMode)
      globalEnable_reg <= regWrData[`UIRQ_MODE_GLOBAL_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      config_reg <= `UIRQ_CFG_RESET;
    else if (usbBusReset)
      config_reg <= {`UIRQ_CFG_FILTERS_ONES, config_reg[1:0]};
    else if (wrConfig)
      config_reg <= regWrData[7:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      enable_reg <= `UIRQ_EN_RESET;
    // bus reset keeps only its own enable
    else if (usbBusReset)
      enable_reg <= enable_reg & `UIRQ_EN_KEEP_MASK;
    else if (wrEnable)
      enable_reg <= regWrData & `UIRQ_EN_IMPL_MASK;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status register, write one to clear, set wins
  always_comb
  begin
    status_next = status_reg;
    if (wrStatus)
      status_next = status_next & ~regWrData;
    status_next = (status_next | setBits) & `UIRQ_EN_IMPL_MASK;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      status_reg <= 32'h00000000;
    else
      status_reg <= status_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output request
  always_comb
  begin
    pending = globalEnable_reg && (|(status_reg & enable_reg));
    newUnmasked = globalEnable_reg && (|(setBits & enable_reg));
    trigger = newUnmasked || (pending && !pendingPrev_reg);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      pendingPrev_reg <= 1'b0;
    else
      pendingPrev_reg <= pending;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin shaper
  uirq_pulse_shaper uShaper (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pulseMode(config_reg[`UIRQ_CFG_PULSE_BIT]),
    .polarityHigh(config_reg[`UIRQ_CFG_POL_BIT]),
    .pending(pending),
    .trigger(trigger),
    .irqOut(irqOut)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb
  begin
    regRdData_next = 32'h00000000;
    unique case (regAddr)
      `UIRQ_OFS_MODE:
        regRdData_next[`UIRQ_MODE_GLOBAL_BIT] = globalEnable_reg;
      `UIRQ_OFS_CONFIG:
        regRdData_next[7:0] = config_reg;
      `UIRQ_OFS_ENABLE:
        regRdData_next = enable_reg;
      `UIRQ_OFS_STATUS:
        regRdData_next = status_reg;
      default:
        // Unmapped reads return zero
        regRdData_next = 32'h00000000;
    endcase
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= 32'h00000000;
    else if (regRead)
      regRdData <= regRdData_next;
    else
      regRdData <= 32'h00000000;
  end

endmodule : usb_periph_irq_config

// ===== hw/uirq_defs.svh
// Register map, field positions, reset values and timing for the interrupt block
// Notes on behaviour
// - 8-bit output configuration register at 10h
// - ACK, NAK, NYET handshakes may raise interrupts
// - Endpoint 0 uses control filter bits 7:6
// - Data IN endpoints use bits 5:4
// - Data OUT endpoints use bits 3:2
// - Control/IN: 00 all, 01 ACK, 1X first NAK
// - OUT: 00 all, 01 ACK+NYET, 1X first NAK
// - First NAK only after preceding ACK; NYET and reset_n also re-arm it here
// - Bit 1 selects level or 60 ns pulse, rounded up to 2 clocks of 50 ns (100 ns)
// - Bit 0 selects low or high polarity
// - Bus reset sets filters, keeps bits 1:0
// - Per-source enables, separate RX and TX per endpoint
// - Global enable clear suppresses the output
// - Enables for SOF, suspend, resume, reset, setup, speed
// - Bus reset clears enables except bus reset
// - Enable register is 24 bits wide
// - Global enable with pending asserts immediately
`ifndef UIRQ_DEFS_SVH
`define UIRQ_DEFS_SVH

// Register byte offsets
`define UIRQ_OFS_MODE 8'h0c
`define UIRQ_OFS_CONFIG 8'h10
`define UIRQ_OFS_ENABLE 8'h14
`define UIRQ_OFS_STATUS 8'h18

// Mode register fields
`define UIRQ_MODE_GLOBAL_BIT 3

// Configuration register fields and values
`define UIRQ_CFG_CTRL_HI 7
`define UIRQ_CFG_CTRL_LO 6
`define UIRQ_CFG_DIN_HI 5
`define UIRQ_CFG_DIN_LO 4
`define UIRQ_CFG_DOUT_HI 3
`define UIRQ_CFG_DOUT_LO 2
`define UIRQ_CFG_PULSE_BIT 1
`define UIRQ_CFG_POL_BIT 0
`define UIRQ_CFG_RESET 8'hfc
`define UIRQ_CFG_FILTERS_ONES 6'h3f

// Enable and status layout
`define UIRQ_BIT_BUS_RESET 0
`define UIRQ_BIT_SOF 1
`define UIRQ_BIT_SUSPEND 2
`define UIRQ_BIT_RESUME 3
`define UIRQ_BIT_SETUP 4
`define UIRQ_BIT_HS_STAT 5
`define UIRQ_BIT_EP_BASE 8
`define UIRQ_EN_RESET 32'h00000000
`define UIRQ_EN_IMPL_MASK 32'h00ffff3f
`define UIRQ_EN_KEEP_MASK 32'h00000001
`define UIRQ_NUM_EP 8

// Pulse width
`define UIRQ_CLK_PERIOD_NS 50
`define UIRQ_PULSE_NS 60
`define UIRQ_PULSE_CYC ((`UIRQ_PULSE_NS + `UIRQ_CLK_PERIOD_NS - 1) / `UIRQ_CLK_PERIOD_NS)

`endif

// ===== hw/uirq_pkg.sv
// Types shared by the interrupt block
package uirq_pkg;

  // Handshake seen by the serial interface engine
  typedef enum logic [1:0] {
    UIRQ_HS_ACK = 2'h0,
    UIRQ_HS_NAK = 2'h1,
    UIRQ_HS_NYET = 2'h2,
    UIRQ_HS_OTHER = 2'h3
  } uirq_hs_type;

  // Pulse shaper states
  typedef enum logic {
    UIRQ_SHAPE_IDLE,
    UIRQ_SHAPE_PULSE
  } uirq_shape_type;

endpackage : uirq_pkg

// ===== hw/uirq_pulse_shaper.sv
// Interrupt pin shaper: level or fixed-width pulse, selectable polarity
`timescale 1ns/1ns
`include "uirq_defs.svh"
module uirq_pulse_shaper
  import uirq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic pulseMode,
  input wire logic polarityHigh,
  input wire logic pending,
  input wire logic trigger,
  output logic irqOut
);

  localparam logic [2:0] PULSE_LEN = 3'(`UIRQ_PULSE_CYC);

  uirq_shape_type state_reg; // Pulse state
  logic [2:0] count_reg; // Cycles left in pulse
  logic active; // Asserted level before polarity

  //////////////////////////////////////////////////////////////////////////////
  // Pulse timer
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= UIRQ_SHAPE_IDLE;
      count_reg <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        UIRQ_SHAPE_IDLE:
        begin
          if (pulseMode && trigger)
          begin
            state_reg <= UIRQ_SHAPE_PULSE;
            count_reg <= PULSE_LEN - 3'h1;
          end
        end
        UIRQ_SHAPE_PULSE:
        begin
          // Count down, then release
          if (count_reg == 3'h0)
            state_reg <= UIRQ_SHAPE_IDLE;
          else
            count_reg <= count_reg - 3'h1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Select level or pulse source
  always_comb
  begin
    if (!pulseMode)
      active = pending;
    else
      active = (state_reg == UIRQ_SHAPE_PULSE);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin register, idle high after reset since polarity resets low
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqOut <= 1'b1;
    else
      irqOut <= polarityHigh ? active : ~active;
  end

endmodule : uirq_pulse_shaper

// ===== sim/uirq_irq_assertions.sv
// Concurrent checks on the interrupt block ports
`timescale 1ns/1ns
`include "uirq_defs.svh"
module uirq_irq_checker
  import uirq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic hsValid,
  input uirq_hs_type hsType,
  input wire logic [2:0] hsEndpoint,
  input wire logic hsDirIn,
  input wire logic [4:0] busEvent,
  input wire logic usbBusReset,
  input wire logic irqOut
);
  logic [7:0] cfgM; // Shadow of configuration
  logic [31:0] enM; // Shadow of enables
  logic glbM; // Shadow of global enable
  logic act; // Pin shows its active level
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  assign act = irqOut == cfgM[0];
  ////////////////////////////////////////////////////////////////////////////
  // Shadows follow writes, bus reset first
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      cfgM <= `UIRQ_CFG_RESET;
    else if (usbBusReset)
      cfgM <= {6'h3f, cfgM[1:0]};
    else if (regWrite && regAddr == `UIRQ_OFS_CONFIG)
      cfgM <= regWrData[7:0];
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      enM <= 32'h0;
    else if (usbBusReset)
      enM <= enM & `UIRQ_EN_KEEP_MASK;
    else if (regWrite && regAddr == `UIRQ_OFS_ENABLE)
      enM <= regWrData & `UIRQ_EN_IMPL_MASK;
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      glbM <= 1'b0;
    else if (regWrite && regAddr == `UIRQ_OFS_MODE)
      glbM <= regWrData[3];
  ////////////////////////////////////////////////////////////////////////////
  chk_read_idle:
    assert property (!$past(regRead) |-> regRdData == 32'h0) else $error("read data not idle");
  chk_cfg_read:
    assert property (regRead && regAddr == `UIRQ_OFS_CONFIG |=> regRdData == {24'h0, $past(cfgM)})
    else $error("config read wrong");
  chk_en_read:
    assert property (regRead && regAddr == `UIRQ_OFS_ENABLE |=> regRdData == $past(enM))
    else $error("enable read wrong");
  chk_mode_read:
    assert property (regRead && regAddr == `UIRQ_OFS_MODE |=> regRdData == {28'h0, $past(glbM), 3'h0})
    else $error("mode read wrong");
  chk_unmapped_zero:
    assert property (regRead && !(regAddr inside {8'h0c, 8'h10, 8'h14, 8'h18}) |=> regRdData == 0)
    else $error("unmapped read not zero");
  chk_global_off:
    assert property (!$past(glbM) && !$past(glbM, 2) && !$past(glbM, 3) && $stable(cfgM[0]) |-> !act)
    else $error("pin active with global enable off");
  chk_pulse_hold:
    assert property (cfgM[1] && $past(cfgM[1]) && $stable(cfgM[0]) && act && !$past(act)
      |=> act || !$stable(cfgM)) else $error("pulse too short");
  chk_ack_level:
    assert property (!cfgM[1] && glbM && hsValid && hsType == UIRQ_HS_ACK && !regWrite
      && enM[{4'h0, hsEndpoint, hsDirIn} + 8'h8] && !usbBusReset ##1 !regWrite && !usbBusReset
      |=> act) else $error("level pin missed acknowledge");
endmodule : uirq_irq_checker
bind usb_periph_irq_config uirq_irq_checker u_chk (.core_clk, .reset_n, .regAddr, .regWrData,
  .regWrite, .regRead, .regRdData, .hsValid, .hsType, .hsEndpoint, .hsDirIn, .busEvent,
  .usbBusReset, .irqOut);

// ===== sim/uirq_host_model.sv
// Host processor model watching the interrupt pin
`timescale 1ns/1ns
module uirq_host_model
(
  input wire logic core_clk,
  input wire logic irqOut,
  input wire logic polCopy,
  output int pulseCnt = 0,
  output int pulseLen = 0
);
  logic actPrev = 1'b0; // Pin was active last edge
  ////////////////////////////////////////////////////////////////////////////
  // mirrored polarity copy
  // Count activations and their length
  always @(posedge core_clk)
  begin
    if ((irqOut === polCopy) && !actPrev)
    begin
      pulseCnt <= pulseCnt + 1;
      pulseLen <= 1;
    end
    else if (irqOut === polCopy)
      pulseLen <= pulseLen + 1;
    actPrev <= irqOut === polCopy;
  end
endmodule : uirq_host_model

// ===== sim/tb.sv
// Self-checking bench for the interrupt block
`timescale 1ns/1ns
`include "uirq_defs.svh"
module tb;
  import uirq_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic hsValid = 1'b0;
  uirq_hs_type hsType = UIRQ_HS_ACK;
  logic [2:0] hsEndpoint = 3'h0;
  logic hsDirIn = 1'b0;
  logic [4:0] busEvent = 5'h0;
  logic usbBusReset = 1'b0;
  logic irqOut;
  logic polCopy = 1'b0; // Host copy of polarity
  int pulseCnt;
  int pulseLen;
  int errorCnt = 0;
  int checked = 0;
  int cycles = 0;
  int idx;
  int n;
  logic [15:0] nakSeen = 16'h0; // NAK seen since last ACK or NYET
  logic [7:0] cfg;
  logic [31:0] en;
  logic [4:0] ev;
  logic [2:0] e;
  logic d;
  logic glb;
  logic exp;
  uirq_hs_type t;
  usb_periph_irq_config u_usb_periph_irq_config (.core_clk(core_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .hsValid(hsValid), .hsType(hsType), .hsEndpoint(hsEndpoint),
    .hsDirIn(hsDirIn), .busEvent(busEvent), .usbBusReset(usbBusReset), .irqOut(irqOut));
  uirq_host_model u_uirq_host_model (.core_clk(core_clk), .irqOut(irqOut), .polCopy(polCopy),
    .pulseCnt(pulseCnt), .pulseLen(pulseLen));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
    forever #25 core_clk = !core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errorCnt++;
      endSim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic endSim();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : endSim
  // One write cycle; config writes also update the host copy
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= dat;
    if (a == `UIRQ_OFS_CONFIG)
      polCopy <= dat[0];
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] want, input string what);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    chk(what, regRdData, want);
  endtask : rd
  task automatic hs(input uirq_hs_type ty, input logic [2:0] ep, input logic dir);
    @(posedge core_clk);
    hsValid <= 1'b1;
    hsType <= ty;
    hsEndpoint <= ep;
    hsDirIn <= dir;
    @(posedge core_clk);
    hsValid <= 1'b0;
  endtask : hs
  // Level pin one cycle after the cause
  task automatic irqIs(input logic want, input logic pol);
    @(posedge core_clk);
    @(negedge core_clk);
    chk("irq pin", {31'h0, irqOut}, {31'h0, want ~^ pol});
  endtask : irqIs
  // Filter outcome for one handshake
  function automatic logic passes(input logic [7:0] c, input uirq_hs_type ty,
    input logic [2:0] ep, input logic dir, input logic first);
    logic [1:0] f;
    f = (ep == 3'h0) ? c[7:6] : (dir ? c[5:4] : c[3:2]);
    case (ty)
      UIRQ_HS_ACK: return 1'b1;
      UIRQ_HS_NYET: return (ep != 3'h0) && !dir;
      UIRQ_HS_NAK: return (f == 2'h0) || (f[1] && first);
      default: return 1'b0;
    endcase
  endfunction : passes
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h17906283));
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(`UIRQ_OFS_CONFIG, 32'hfc, "config");
    rd(`UIRQ_OFS_ENABLE, 32'h0, "enable");
    rd(`UIRQ_OFS_MODE, 32'h0, "mode");
    rd(8'h20, 32'h0, "unmapped");
    repeat (60)
    begin
      cfg = 8'($urandom) & 8'hfd;
      en = $urandom;
      glb = 1'($urandom);
      e = 3'($urandom);
      d = 1'($urandom);
      t = uirq_hs_type'(2'($urandom));
      idx = 8 + 2 * int'(e) + int'(d);
      exp = passes(cfg, t, e, d, !nakSeen[{e, d}]);
      if (t == UIRQ_HS_NAK)
        nakSeen[{e, d}] = 1'b1;
      else if (t != UIRQ_HS_OTHER)
        nakSeen[{e, d}] = 1'b0;
      wr(`UIRQ_OFS_CONFIG, {24'h0, cfg});
      wr(`UIRQ_OFS_ENABLE, en);
      wr(`UIRQ_OFS_MODE, {28'h0, glb, 3'h0});
      wr(`UIRQ_OFS_STATUS, 32'hffffffff);
      hs(t, e, d);
      irqIs(exp && en[idx] && glb, cfg[0]);
      rd(`UIRQ_OFS_STATUS, 32'(exp) << idx, "status");
      wr(`UIRQ_OFS_MODE, 32'h8);
      irqIs(exp && en[idx], cfg[0]);
      wr(`UIRQ_OFS_STATUS, 32'hffffffff);
      irqIs(1'b0, cfg[0]);
    end
    ev = 5'($urandom) | 5'h01;
    wr(`UIRQ_OFS_ENABLE, {26'h0, ev, 1'b0});
    @(posedge core_clk);
    busEvent <= ev;
    @(posedge core_clk);
    busEvent <= 5'h0;
    irqIs(1'b1, cfg[0]);
    rd(`UIRQ_OFS_STATUS, {26'h0, ev, 1'b0}, "event status");
    for (int p = 0; p < 2; p++)
    begin
      wr(`UIRQ_OFS_CONFIG, {30'h3f, 1'b1, p[0]});
      wr(`UIRQ_OFS_STATUS, 32'hffffffff);
      wr(`UIRQ_OFS_ENABLE, 32'h00ffff3f);
      repeat (4) @(posedge core_clk);
      n = pulseCnt;
      hs(UIRQ_HS_ACK, 3'h1, 1'b1);
      repeat (6) @(posedge core_clk);
      chk("pulse count", pulseCnt - n, 32'h1);
      chk("pulse width", pulseLen, 32'(`UIRQ_PULSE_CYC));
    end
    wr(`UIRQ_OFS_ENABLE, 32'hffffffff);
    rd(`UIRQ_OFS_ENABLE, 32'h00ffff3f, "enable width");
    wr(`UIRQ_OFS_CONFIG, 32'h01);
    @(posedge core_clk);
    usbBusReset <= 1'b1;
    @(posedge core_clk);
    usbBusReset <= 1'b0;
    rd(`UIRQ_OFS_CONFIG, 32'hfd, "config bus reset");
    rd(`UIRQ_OFS_ENABLE, 32'h1, "enable bus reset");
    rd(`UIRQ_OFS_MODE, 32'h8, "mode bus reset");
    endSim();
  end
endmodule : tb
